// *** rtl/psrc_ctrl.sv ***
// Mode select and configuration controller for a radio transceiver.
// Assumes feature pins and strap are synchronous to clk; pins resolve on the board.
//
// Behaviour
// RULE_01 - Legacy mode: controller idle, serial configuration lines never driven.
// RULE_02 - Serial mode: sample the eight feature-select pins and detect changes.
// RULE_03 - A detected change writes new values to radio registers automatically.
// RULE_04 - Serial mode: controller alone drives select, clock and data lines.
// RULE_05 - Legacy mode: clock and data pins are inputs carrying control lines.
// RULE_06 - Legacy pair selects sleep, OOK transmit, ASK transmit or receive.
// RULE_07 - Mode choice is taken only at power-up, fixed until next.
// RULE_08 - Select line grounded in legacy mode, chip select in serial mode.
// RULE_09 - Host raises wake pin after power-up; otherwise controller stays inactive.
// RULE_10 - Host sets pin levels for ASK 2.4 kbps start-vector reception.
// RULE_11 - Host toggles start-vector enable low then high to re-arm.
// RULE_12 - Rate-select high picks 2.4 kbps, low picks 19.2 kbps.
// RULE_13 - Data transfers to a control register after each eight bits.
// RULE_14 - Radio captures each data bit on configuration clock rising edge.
// RULE_15 - Periodic sampling, compare with last written, one update per difference.
`default_nettype none
module psrc_ctrl
    import psrc_pkg::*;
#(
    parameter int unsigned SCAN_PERIOD = SCAN_CYCLES
) (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic                 powerup_mode_jumper,
    input  wire logic [FEAT_BITS-1:0] feature_pins,
    input  wire logic                 serial_cfg_clock_i,
    input  wire logic                 serial_cfg_data_i,
    output psrc_pins_t                cfg_pins,
    output logic                      serial_configuration_mode,
    output logic                      legacy_pin_mode,
    output psrc_op_t                  legacy_op_q,
    output logic                      rate_is_slow_q,
    output logic                      update_busy
);
    if (SCAN_PERIOD < 2) begin : g_scan_chk
        $error("SCAN_PERIOD must be at least two");
    end
    // The write index is one bit, so it can walk through two bytes at most
    if (NUM_WRITES < 1 || NUM_WRITES > 2) begin : g_writes_chk
        $error("The one-bit write index serves one or two writes only");
    end
    if (FEAT_BITS <= FEAT_WAKE) begin : g_feat_chk
        $error("Feature word too narrow for the wake pin");
    end

    typedef enum logic [2:0] {
        ST_STRAP, ST_LEGACY, ST_ASLEEP, ST_SCAN, ST_SEND, ST_WAIT
    } psrc_state_t;

    function automatic logic [7:0] cfg_byte(input logic [2:0] addr,
                                            input logic [FEAT_BITS-1:0] f);
        if (addr == REG_MODE_ADDR) begin
            cfg_byte = {addr, f[FEAT_INTF], f[FEAT_SPREAD], f[FEAT_SLEEP],
                        f[FEAT_MOD], f[FEAT_TX_RX]};
        end else begin
            cfg_byte = {addr, 3'h0, f[FEAT_SV_EN], f[FEAT_RATE]};  // RULE_12
        end
    endfunction : cfg_byte

    psrc_state_t          st_q, st_d;
    logic [31:0]          tick_q, tick_d;
    logic [FEAT_BITS-1:0] last_q, last_d, snap_q, snap_d;
    logic                 idx_q, idx_d, start, scan_due;
    psrc_op_t             op_d;
    logic                 rate_d;
    logic                 sh_busy, sh_done, sh_cs, sh_sclk, sh_sdat;
    logic [7:0]           sh_byte;

    always_comb begin
        st_d   = st_q;
        last_d = last_q;
        snap_d = snap_q;
        idx_d  = idx_q;
        start  = 1'b0;
        case (st_q)
            ST_STRAP: begin
                // Strap caught once after reset release and then held
                st_d = powerup_mode_jumper ? ST_ASLEEP : ST_LEGACY;  // RULE_07
            end
            ST_LEGACY: begin
                st_d = ST_LEGACY;  // RULE_01
            end
            ST_ASLEEP: begin
                if (feature_pins[FEAT_WAKE]) begin  // RULE_09
                    st_d   = ST_SEND;
                    snap_d = feature_pins;
                    idx_d  = 1'b0;
                end
            end
            ST_SCAN: begin
                if (scan_due && (feature_pins != last_q)) begin  // RULE_02
                    st_d   = ST_SEND;  // RULE_15
                    snap_d = feature_pins;
                    idx_d  = 1'b0;
                end
            end
            // Start only on an idle engine, so two bytes never overlap
            ST_SEND: begin
                start = !sh_busy;  // RULE_03
                if (!sh_busy) begin
                    st_d = ST_WAIT;
                end
            end
            // Pin changes made during an update wait for the next scan
            ST_WAIT: begin
                if (sh_done) begin
                    if (idx_q == 1'(NUM_WRITES - 1)) begin
                        last_d = snap_q;
                        st_d   = ST_SCAN;
                    end else begin
                        idx_d = 1'b1;
                        st_d  = ST_SEND;
                    end
                end
            end
            default: st_d = ST_STRAP;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q   <= ST_STRAP;
            last_q <= FEAT_RESET;
            snap_q <= FEAT_RESET;
            idx_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            last_q <= last_d;
            snap_q <= snap_d;
            idx_q  <= idx_d;
        end
    end

    // Scan timer counts only in scan state and holds while an update runs
    always_comb begin
        tick_d   = tick_q;
        scan_due = 1'b0;
        if (st_q == ST_SCAN) begin
            if (tick_q == SCAN_PERIOD - 1) begin
                tick_d   = 32'h0;
                scan_due = 1'b1;  // RULE_15
            end else begin
                tick_d = tick_q + 32'h1;
            end
        end else if (st_q == ST_ASLEEP) begin
            tick_d = 32'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_q <= 32'h0;
        end else begin
            tick_q <= tick_d;
        end
    end

    // Legacy decode: control zero is the low bit, control one the high bit
    always_comb begin
        if (st_q == ST_LEGACY) begin
            op_d = psrc_op_t'({serial_cfg_data_i, serial_cfg_clock_i});  // RULE_06
        end else begin
            // The pair carries our serial port outside legacy mode
            op_d = PSRC_SLEEP;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            legacy_op_q <= PSRC_SLEEP;
        end else begin
            legacy_op_q <= op_d;
        end
    end

    // Rate follows the value committed with the last write, in the same cycle
    always_comb begin
        rate_d = last_d[FEAT_RATE];  // RULE_12
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rate_is_slow_q <= 1'b0;
        end else begin
            rate_is_slow_q <= rate_d;
        end
    end

    assign sh_byte = cfg_byte(idx_q ? REG_RATE_ADDR : REG_MODE_ADDR, snap_q);

    psrc_shifter u_shifter (
        .clk     (clk),
        .sys_rst (sys_rst),
        .start   (start),
        .byte_in (sh_byte),
        .busy    (sh_busy),
        .done    (sh_done),
        .cs_q    (sh_cs),
        .sclk_q  (sh_sclk),
        .sdat_q  (sh_sdat)
    );

    assign legacy_pin_mode           = (st_q == ST_LEGACY);
    assign serial_configuration_mode = (st_q != ST_LEGACY) && (st_q != ST_STRAP);
    assign update_busy               = (st_q == ST_SEND) || (st_q == ST_WAIT);

    // Legacy: clock and data released as inputs, select held low
    always_comb begin
        cfg_pins.cs_o    = serial_configuration_mode & sh_cs;  // RULE_08
        cfg_pins.cs_oe   = 1'b1;  // RULE_08
        cfg_pins.sclk_o  = sh_sclk;  // RULE_14
        cfg_pins.sclk_oe = serial_configuration_mode;  // RULE_04 RULE_05
        cfg_pins.sdat_o  = sh_sdat;
        cfg_pins.sdat_oe = serial_configuration_mode;  // RULE_04 RULE_05
    end
endmodule : psrc_ctrl
`default_nettype wire

// *** rtl/psrc_pkg.sv ***
// Package for the pin-scan radio configuration controller.
// Assumes a single 25 MHz clock and synchronous active-high reset.
`default_nettype none
package psrc_pkg;
    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned SCAN_US       = 1000;
    localparam int unsigned SCAN_CYCLES   = (CLK_HZ / 1_000_000) * SCAN_US;
    localparam int unsigned SCLK_HALF_NS  = 200;
    localparam int unsigned CLK_NS        = 40;
    localparam int unsigned SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned BYTE_BITS     = 8;
    localparam int unsigned FEAT_BITS     = 8;
    localparam int unsigned NUM_WRITES    = 2;

    // Feature-select pin positions within the sampled word (module pins 8..15)
    localparam int unsigned FEAT_TX_RX    = 0;
    localparam int unsigned FEAT_MOD      = 1;
    localparam int unsigned FEAT_SLEEP    = 2;
    localparam int unsigned FEAT_SV_EN    = 3;
    localparam int unsigned FEAT_SPREAD   = 4;
    localparam int unsigned FEAT_INTF     = 5;
    localparam int unsigned FEAT_RATE     = 6;
    localparam int unsigned FEAT_WAKE     = 7;

    // Radio control register addresses, placed in the top bits of each byte
    localparam logic [2:0] REG_MODE_ADDR  = 3'h1;
    localparam logic [2:0] REG_RATE_ADDR  = 3'h2;
    localparam logic [7:0] FEAT_RESET     = 8'h00;

    typedef enum logic [1:0] {
        PSRC_SLEEP,
        PSRC_TX_OOK,
        PSRC_TX_ASK,
        PSRC_RX
    } psrc_op_t;

    typedef struct packed {
        logic cs_o;
        logic cs_oe;
        logic sclk_o;
        logic sclk_oe;
        logic sdat_o;
        logic sdat_oe;
    } psrc_pins_t;
endpackage : psrc_pkg
`default_nettype wire

// *** rtl/psrc_shifter.sv ***
// Serial write engine: shifts one byte MSB first under chip select.
// Assumes the caller holds start for one cycle only while idle.
`default_nettype none
module psrc_shifter
    import psrc_pkg::*;
#(
    parameter int unsigned HALF_CYC = SCLK_HALF_CYC
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       start,
    input  wire logic [7:0] byte_in,
    output logic            busy,
    output logic            done,
    output logic            cs_q,
    output logic            sclk_q,
    output logic            sdat_q
);
    // The half-period divider is sixteen bits wide
    if (HALF_CYC < 1 || HALF_CYC > 32'h0001_0000) begin : g_half_chk
        $error("HALF_CYC must lie between one and the divider range");
    end

    logic [7:0]  sr_q, sr_d;
    logic [3:0]  bit_q, bit_d;
    logic [15:0] div_q, div_d;
    logic        cs_d, sclk_d, sdat_d, done_q, done_d;

    always_comb begin
        sr_d   = sr_q;
        bit_d  = bit_q;
        div_d  = div_q;
        cs_d   = cs_q;
        sclk_d = sclk_q;
        sdat_d = sdat_q;
        done_d = 1'b0;
        if (!cs_q) begin
            if (start) begin
                cs_d   = 1'b1;
                sr_d   = {byte_in[6:0], 1'b0};
                sdat_d = byte_in[7];
                bit_d  = 4'h0;
                div_d  = 16'h0000;
            end
        end else if (div_q == 16'(HALF_CYC - 1)) begin
            div_d = 16'h0000;
            if (!sclk_q) begin
                // Data already stable, so the radio captures on this rising edge
                sclk_d = 1'b1;
            end else begin
                sclk_d = 1'b0;
                if (bit_q == 4'(BYTE_BITS - 1)) begin
                    // Byte complete: the eighth rising edge already committed the group of eight; drop select
                    cs_d   = 1'b0;  // RULE_13
                    sdat_d = 1'b0;
                    done_d = 1'b1;
                end else begin
                    bit_d  = bit_q + 4'h1;
                    sdat_d = sr_q[7];
                    sr_d   = {sr_q[6:0], 1'b0};
                end
            end
        end else begin
            div_d = div_q + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sr_q   <= 8'h00;
            bit_q  <= 4'h0;
            div_q  <= 16'h0000;
            cs_q   <= 1'b0;
            sclk_q <= 1'b0;
            sdat_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            sr_q   <= sr_d;
            bit_q  <= bit_d;
            div_q  <= div_d;
            cs_q   <= cs_d;
            sclk_q <= sclk_d;
            sdat_q <= sdat_d;
            done_q <= done_d;
        end
    end

    assign busy = cs_q;
    assign done = done_q;
endmodule : psrc_shifter
`default_nettype wire

// *** sim/psrc_radio_model.sv ***
// Radio-side model: shifts configuration bits into bytes under select.
// Assumes resolved select, clock and data lines from the bench.
`default_nettype none
module psrc_radio_model (
    input  wire logic       sel,
    input  wire logic       sck,
    input  wire logic       sdi,
    output logic [7:0]      prev_b,
    output logic [7:0]      last_b,
    output var int          nb
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh;
    int         nbit;
    initial begin
        prev_b = 8'h00;
        last_b = 8'h00;
        nb = 0;
        nbit = 0;
    end
    // A frame restarts the bit count so a torn frame cannot shift bytes
    always @(posedge sel) nbit = 0;
    always @(posedge sck) begin
        if (sel) begin
            sh = {sh[6:0], sdi};
            nbit = nbit + 1;
            if (nbit % 8 == 0) begin
                prev_b = last_b;
                last_b = sh;
                nb = nb + 1;
            end
        end
    end
endmodule : psrc_radio_model
`default_nettype wire

// *** sim/psrc_ctrl_sva.sv ***
// Checker for the configuration controller ports.
// Assumes it is bound into every controller instance.
`default_nettype none
module psrc_ctrl_sva
    import psrc_pkg::*;
#(
    parameter int unsigned SCAN_PERIOD = SCAN_CYCLES
) (
    input wire logic                 clk,
    input wire logic                 sys_rst,
    input wire logic                 powerup_mode_jumper,
    input wire logic [FEAT_BITS-1:0] feature_pins,
    input wire logic                 serial_cfg_clock_i,
    input wire logic                 serial_cfg_data_i,
    input wire psrc_pins_t           cfg_pins,
    input wire logic                 serial_configuration_mode,
    input wire logic                 legacy_pin_mode,
    input wire psrc_op_t             legacy_op_q,
    input wire logic                 rate_is_slow_q,
    input wire logic                 update_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_legacy_quiet: assert property (
        legacy_pin_mode |-> !cfg_pins.sclk_oe && !cfg_pins.sdat_oe && !update_busy)
        else $error("serial lines active in legacy mode");
    a_cs_grounded: assert property (
        legacy_pin_mode |-> cfg_pins.cs_oe && !cfg_pins.cs_o)
        else $error("select not grounded in legacy mode");
    a_serial_owns: assert property (
        serial_configuration_mode |-> cfg_pins.sclk_oe && cfg_pins.sdat_oe && cfg_pins.cs_oe)
        else $error("serial lines not driven in serial mode");
    a_mode_fixed: assert property (
        (serial_configuration_mode || legacy_pin_mode)
        |=> $stable({serial_configuration_mode, legacy_pin_mode}))
        else $error("mode changed after power-up");
    a_op_decode: assert property (
        legacy_pin_mode |=> legacy_op_q ==
        psrc_op_t'({$past(serial_cfg_data_i), $past(serial_cfg_clock_i)}))
        else $error("legacy state decode wrong");
    a_serial_sleep: assert property (
        serial_configuration_mode |-> legacy_op_q == PSRC_SLEEP)
        else $error("legacy state set in serial mode");
    a_byte_frame: assert property (
        $rose(cfg_pins.cs_o) |-> ##79 cfg_pins.cs_o ##1 !cfg_pins.cs_o)
        else $error("byte frame length wrong");
    a_data_steady: assert property (
        $rose(cfg_pins.sclk_o) |-> cfg_pins.cs_o && $stable(cfg_pins.sdat_o))
        else $error("data moved at clock rise");
    a_busy_frame: assert property (
        cfg_pins.cs_o |-> update_busy)
        else $error("frame outside update");
    a_rate_update: assert property (
        $changed(rate_is_slow_q) |-> update_busy || $past(update_busy))
        else $error("rate changed outside update");
    c_frame: cover property ($rose(cfg_pins.cs_o));
    c_legacy_rx: cover property (legacy_op_q == PSRC_RX);
    c_slow: cover property ($fell(rate_is_slow_q));
endmodule : psrc_ctrl_sva
bind psrc_ctrl psrc_ctrl_sva #(.SCAN_PERIOD(SCAN_PERIOD)) u_sva (
    .clk(clk), .sys_rst(sys_rst), .powerup_mode_jumper(powerup_mode_jumper),
    .feature_pins(feature_pins), .serial_cfg_clock_i(serial_cfg_clock_i),
    .serial_cfg_data_i(serial_cfg_data_i), .cfg_pins(cfg_pins),
    .serial_configuration_mode(serial_configuration_mode),
    .legacy_pin_mode(legacy_pin_mode), .legacy_op_q(legacy_op_q),
    .rate_is_slow_q(rate_is_slow_q), .update_busy(update_busy));
`default_nettype wire

// *** sim/tb_top.sv ***
// Bench: serial-mode updates first, then a second power-up in legacy mode.
// Assumes the radio model and checker are compiled before it.
`default_nettype none
module tb_top
    import psrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       jumper = 1'b1;
    logic [7:0] feat = 8'h4A;
    logic       c0 = 1'b0;
    logic       c1 = 1'b0;
    psrc_pins_t pins;
    psrc_op_t   op;
    logic       ser_m, leg_m, slow, busy;
    logic [7:0] prev_b, last_b;
    int         nb, n_fail, cmp_count, cyc;
    // Start-vector receive set-up, then its enable dropped and raised to re-arm
    logic [7:0] tbl [5] = '{8'hCA, 8'hC2, 8'hCA, 8'h8A, 8'hB5};
    psrc_op_t   ops [4] = '{PSRC_SLEEP, PSRC_TX_OOK, PSRC_TX_ASK, PSRC_RX};
    // Legacy lines are driven by the bench whenever the controller lets go
    wire sck = pins.sclk_oe ? pins.sclk_o : c0;
    wire sdi = pins.sdat_oe ? pins.sdat_o : c1;
    psrc_ctrl #(.SCAN_PERIOD(8)) dut (.clk(clk), .sys_rst(sys_rst),
        .powerup_mode_jumper(jumper), .feature_pins(feat), .serial_cfg_clock_i(sck),
        .serial_cfg_data_i(sdi), .cfg_pins(pins), .serial_configuration_mode(ser_m),
        .legacy_pin_mode(leg_m), .legacy_op_q(op), .rate_is_slow_q(slow),
        .update_busy(busy));
    psrc_radio_model radio (.sel(pins.cs_o), .sck(sck), .sdi(sdi),
        .prev_b(prev_b), .last_b(last_b), .nb(nb));
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d failures %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc_n(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc_n
    task automatic wait_bytes(input int n);
        int k;
        k = 0;
        while ((nb < n || busy !== 1'b0) && k < 3000) begin
            @(negedge clk);
            k++;
        end
        chk("byte count", 8'(nb), 8'(n));
    endtask : wait_bytes
    function automatic logic [7:0] mode_b(input logic [7:0] f);
        return {REG_MODE_ADDR, f[5], f[4], f[2], f[1], f[0]};
    endfunction : mode_b
    initial begin
        cyc_n(4);
        sys_rst = 1'b0;
        cyc_n(40);
        chk("no wake bytes", 8'(nb), 8'h00);
        chk("serial mode", 8'(ser_m), 8'h01);
        for (int i = 0; i < 5; i++) begin
            feat = tbl[i];
            wait_bytes(2 * i + 2);
            chk("mode byte", prev_b, mode_b(tbl[i]));
            chk("rate byte", last_b, {REG_RATE_ADDR, 3'h0, tbl[i][3], tbl[i][6]});
            chk("slow rate", 8'(slow), 8'(tbl[i][6]));
        end
        cyc_n(60);
        chk("no resend", 8'(nb), 8'h0A);
        sys_rst = 1'b1;
        jumper = 1'b0;
        cyc_n(4);
        sys_rst = 1'b0;
        cyc_n(3);
        chk("legacy mode", 8'(leg_m), 8'h01);
        for (int j = 0; j < 4; j++) begin
            {c1, c0} = 2'(j);
            feat = ~feat;
            cyc_n(2);
            chk("legacy op", 8'(op), 8'(ops[j]));
            chk("clock oe", 8'(pins.sclk_oe), 8'h00);
            chk("select", 8'(pins.cs_o), 8'h00);
        end
        cyc_n(40);
        chk("legacy bytes", 8'(nb), 8'h0A);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
